// File: hdl/dmh_debug_ctrl.sv
/*
 * Debug monitor and halting step control for one processor core.
 * Decides pend/escalate/ignore for debug events, sequences halting
 * stepping and decodes the halt/step/mask control triple.
 * Assumes the core reports retirement, exception entry and priorities
 * synchronously on core_clk; debugger accesses arrive on the reg port.
 */
// Implementation choices: strobed register access and the register offsets.
//
// Contract
// - Monitor exception enabled only with monitor_enable
// - Pend monitor only on eligible event, priority
// - Low priority breakpoint instruction escalates hard fault
// - Low priority watchpoint pends; others ignored (the code ignores a low priority watchpoint too)
// - Pending bit set pends monitor exception
// - Taking monitor exception clears pending bit
// - Fault status updates with pending bit set
// - Stepped instruction reads may return anything
// - Async monitor event taken in bounded time
// - Stepped wait instruction retires on wake
// - Stepping active: enabled, permitted, step, running
// - One step outcome per halted exit
// - At most one context push per step
// - After step set halted status, halt request
// - Halt if permitted, else keep running
// - Mask blocks service call, tick, external irqs
// - Permitted exception steps into handler, halts
// - Mask treated zero unless halting enabled, permitted
// - Secure exceptions ignore mask without secure debug
// - Control write decodes exit, step, remain
// - Halting disabled ignores halt, step, mask
// - Halt request and permitted means halt
`default_nettype none
module dmh_debug_ctrl
    import dmh_pkg::*;
#(
    parameter int PRIO_W = 8                   // Priority value width
)
(
    input  wire logic              core_clk,        // Core clock
    input  wire logic              rstn,            // Sync reset, low
    // Register port
    input  wire logic [7:0]        reg_addr,        // Byte address
    input  wire logic [31:0]       reg_wdata,       // Write data
    input  wire logic              reg_wr,          // Write strobe
    input  wire logic              reg_rd,          // Read strobe
    output logic      [31:0]       reg_rdata,       // Read data, next cycle
    // Core status inputs
    input  wire logic              halting_permitted, // Halting allowed
    input  wire logic              secure_debug_enabled, // Secure debug
    input  wire logic              security_ext,    // Security ext present
    input  wire logic [PRIO_W-1:0] exec_priority,   // Current exec priority
    input  wire logic [PRIO_W-1:0] monitor_priority, // Monitor group prio
    // Debug events (one-cycle pulses)
    input  wire logic              evt_breakpoint_instruction,        // Breakpoint instruction
    input  wire logic              evt_watch,       // Watchpoint match
    input  wire logic              evt_other,       // Other monitor event
    input  wire logic              evt_halting,     // Event enters halt
    // Core progress
    input  wire logic              instr_retired,   // Instruction retired
    input  wire logic              exc_entry,       // Context push occurred
    input  wire logic              monitor_taken,   // Monitor exc taken
    input  wire logic              wait_sleeping,   // Stepped wait asleep
    input  wire logic              wake_event,      // Wake from wait
    input  wire logic              exc_secure,      // Pending exc is secure
    // Outputs to core
    output logic                   monitor_pend_req, // Pend monitor exc
    output logic                   hard_fault_req,  // Escalate to hard_fault_exception
    output logic                   core_halt,       // Hold core in debug
    output logic                   step_active,     // Stepping active
    output logic                   irq_block,       // Block tick/svc/irqs
    output logic                   allow_exc_entry  // Core may push context
);

    // Registered control/status state
    logic       monitor_enable;     // Monitor enable bit
    logic       monitor_pending;    // Monitor pending bit
    logic       halting_debug_enable; // Halting debug enable
    logic       halt_req;           // Halt request bit
    logic       step_req;           // Step request bit
    logic       step_interrupt_mask; // Step interrupt mask
    logic [3:0] fault_status;       // Debug fault status bits
    logic [1:0] sync_perm;          // Synchroniser for permit pin
    logic [1:0] sync_sde;           // Synchroniser for secure debug
    logic       perm;               // Synchronised halting permitted
    logic       sde;                // Synchronised secure debug
    logic       pushed;             // Context already pushed this step
    dmh_state_e state;              // Step sequencer state
    dmh_state_e next_state;         // Next sequencer state

    // Decoded strobes
    logic wr_mon;                   // Write monitor control
    logic wr_halt;                  // Write halting control
    logic wr_fs;                    // Write fault status
    logic prio_ok;                  // Monitor outranks execution
    logic mon_set;                  // Event sets pending this cycle
    logic step_done;                // Step finished this cycle
    logic halted;                   // Core presently halted

    // Pins from outside the clock domain pass two flops
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            sync_perm <= 2'b00;
            sync_sde  <= 2'b00;
        end
        else
        begin
            sync_perm <= {sync_perm[0], halting_permitted};
            sync_sde  <= {sync_sde[0], secure_debug_enabled};
        end
    end
    assign perm = sync_perm[1];
    assign sde  = sync_sde[1];

    assign wr_mon  = reg_wr && (reg_addr == OFF_MON_CTRL);
    assign wr_halt = reg_wr && (reg_addr == OFF_HALT_CTRL);
    assign wr_fs   = reg_wr && (reg_addr == OFF_FAULT_ST);
    assign halted  = (state == DMH_HALTED);

    // Lower number means higher urgency, as in the core
    assign prio_ok = monitor_enable && (monitor_priority < exec_priority);

    // Event eligible for monitor, not for halt, priority high enough
    assign mon_set = !evt_halting && prio_ok
                   && (evt_breakpoint_instruction || evt_watch || evt_other);

    // Low priority: breakpoint escalates; watchpoint not pended here
    assign hard_fault_req = !evt_halting && monitor_enable && !prio_ok
                          && evt_breakpoint_instruction;

    assign monitor_pend_req = monitor_pending;

    // Monitor control register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            monitor_enable  <= 1'b0;
            monitor_pending <= 1'b0;
        end
        else
        begin
            if (wr_mon)
                monitor_enable <= reg_wdata[MONITOR_ENABLE_BIT];
            // Hardware set wins over both take and software clear
            if (mon_set)
                monitor_pending <= 1'b1;
            else if (monitor_taken)
                monitor_pending <= 1'b0;
            else if (wr_mon)
                monitor_pending <= reg_wdata[MONITOR_PENDING_BIT];
        end
    end

    // Fault status, sticky, write one to clear
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            fault_status <= 4'h0;
        else
        begin
            // Set terms OR'd last so a set beats a same-cycle clear
            fault_status <= (fault_status
                             & ~(wr_fs ? reg_wdata[3:0] : 4'h0))
                          | {mon_set && evt_other,
                             mon_set && evt_watch,
                             mon_set && evt_breakpoint_instruction,
                             step_done || (evt_halting && halting_debug_enable)
                            };
        end
    end

    // Sequencer: halt entry, exit decode, single step
    always_comb
    begin
        next_state = state;
        step_done  = 1'b0;
        case (state)
            DMH_RUN:
                // Halt request or halting event stops the core
                if (halting_debug_enable && perm
                    && (halt_req || evt_halting))
                    next_state = DMH_HALTED;
            DMH_HALTED:
                // Exit when the debugger clears halt or halting debug enable
                if (!halt_req || !halting_debug_enable)
                    next_state = (step_req && halting_debug_enable)
                               ? DMH_STEP : DMH_RUN;
            DMH_STEP:
                // Retire, wake from wait, or enter an exception
                if (instr_retired || exc_entry
                    || (wait_sleeping && wake_event))
                begin
                    step_done  = 1'b1;
                    next_state = DMH_DONE;
                end
            DMH_DONE:
                // Halt before next instruction if still permitted
                next_state = perm ? DMH_HALTED : DMH_RUN;
            default:
                next_state = DMH_RUN;
        endcase
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            state <= DMH_RUN;
        else
            state <= next_state;
    end

    // One context push per step sequence
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            pushed <= 1'b0;
        else if (state != DMH_STEP)
            pushed <= 1'b0;
        else if (exc_entry)
            pushed <= 1'b1;
    end

    // Halting control register
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
        begin
            halting_debug_enable <= 1'b0;
            halt_req             <= 1'b0;
            step_req             <= 1'b0;
            step_interrupt_mask  <= 1'b0;
        end
        else
        begin
            if (wr_halt)
            begin
                halting_debug_enable <= reg_wdata[HDE_BIT];
                halt_req             <= reg_wdata[HALT_BIT];
                // Step/mask taken while halted or with halting debug disabled;
                // changes while running with it enabled are simply dropped
                if (halted || !halting_debug_enable)
                begin
                    step_req            <= reg_wdata[STEP_BIT];
                    step_interrupt_mask <= reg_wdata[MASK_BIT];
                end
            end
            // Hardware set beats a same-cycle software clear
            if (step_done
                || (evt_halting && halting_debug_enable && !halted))
                halt_req <= 1'b1;
        end
    end

    // Core controls; stepping needs enable, permit, step, running
    assign step_active = halting_debug_enable && perm && step_req
                       && !halted;
    assign core_halt   = halting_debug_enable && (halted
                       || (state == DMH_DONE && perm));
    // Mask honoured only under enabled, permitted halting debug
    assign irq_block   = halting_debug_enable && perm
                       && step_interrupt_mask
                       && !(security_ext && !sde && exc_secure);
    // Permitted exceptions enter once, then halt at handler start
    assign allow_exc_entry = !(state == DMH_STEP && pushed);

    // Read data: one cycle after the strobe, held until the next read
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            reg_rdata <= RST_ZERO;
        else if (reg_rd)
        begin
            reg_rdata <= RST_ZERO;
            case (reg_addr)
                OFF_MON_CTRL:
                begin
                    reg_rdata[MONITOR_ENABLE_BIT]   <= monitor_enable;
                    // Stepped reads see live value; any value is legal
                    reg_rdata[MONITOR_PENDING_BIT] <= monitor_pending;
                end
                OFF_HALT_CTRL:
                begin
                    reg_rdata[HDE_BIT]       <= halting_debug_enable;
                    reg_rdata[HALT_BIT]      <= halt_req;
                    reg_rdata[STEP_BIT]      <= step_req;
                    reg_rdata[MASK_BIT]      <= step_interrupt_mask;
                    reg_rdata[HALTED_ST_BIT] <= halted;
                    reg_rdata[SDE_ST_BIT]    <= sde;
                end
                OFF_FAULT_ST:
                    reg_rdata[3:0] <= fault_status;
                default:
                    reg_rdata <= RST_ZERO; // Unmapped reads zero
            endcase
        end
    end

endmodule : dmh_debug_ctrl
`default_nettype wire

// File: hdl/dmh_pkg.sv
/*
 * Package for the debug monitor and halt/step control block.
 * Holds register offsets, field positions, reset values and state
 * encodings. Assumes a plain address/strobe register port on core_clk.
 */
`default_nettype none
package dmh_pkg;
    // Register word offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] OFF_MON_CTRL  = 8'h00; // Monitor control reg
    localparam logic [7:0] OFF_HALT_CTRL = 8'h04; // Halting control/status
    localparam logic [7:0] OFF_FAULT_ST  = 8'h08; // Debug fault status reg
    // Monitor control fields
    localparam int MONITOR_ENABLE_BIT    = 0;            // Monitor enable
    localparam int MONITOR_PENDING_BIT  = 1;            // Monitor pending
    // Halting control fields
    localparam int HDE_BIT       = 0;            // Halting debug enable
    localparam int HALT_BIT      = 1;            // Halt request
    localparam int STEP_BIT      = 2;            // Step request
    localparam int MASK_BIT      = 3;            // Step interrupt mask
    localparam int HALTED_ST_BIT = 16;           // Core halted status
    localparam int SDE_ST_BIT    = 17;           // Secure debug enabled
    // Fault status fields
    localparam int FS_HALTED_BIT = 0;            // Halted/step event seen
    localparam int FS_BREAKPOINT_INSTRUCTION_BIT   = 1;            // Breakpoint event
    localparam int FS_WATCH_BIT  = 2;            // Watchpoint event
    localparam int FS_EXT_BIT    = 3;            // Other async event
    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Step sequencer states, Gray along run->halted->step->done
    typedef enum logic [1:0]
    {
        DMH_RUN    = 2'b00,
        DMH_HALTED = 2'b01,
        DMH_STEP   = 2'b11,
        DMH_DONE   = 2'b10
    } dmh_state_e;
endpackage : dmh_pkg
`default_nettype wire

// File: sim/dmh_dbg.sv
/*
 * Debugger model: one-cycle write and read strobes on the register port.
 * Assumes the bench calls its tasks one after another.
 */
`default_nettype none
module dmh_dbg
(
    input  wire logic        core_clk,  // Core clock
    output var  logic [7:0]  reg_addr,  // Byte address
    output var  logic [31:0] reg_wdata, // Write data
    output var  logic        reg_wr,    // Write strobe
    output var  logic        reg_rd,    // Read strobe
    input  wire logic [31:0] reg_rdata  // Read data, next cycle
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 42'h0;
    end
    // Step and mask only rewritten by callers while halted
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d; // Stale data must not pass for valid
    endtask : wr
    // Data stands from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : dmh_dbg
`default_nettype wire

// File: sim/dmh_debug_ctrl_asserts.sv
/*
 * Port-level checker for the debug monitor and halt/step block.
 * Bound to dmh_debug_ctrl; sees only its ports, single core_clk domain.
 */
`default_nettype none
module dmh_debug_ctrl_asserts
    import dmh_pkg::*;
#(
    parameter int PRIO_W = 8 // Priority width
)
(
    input wire logic              core_clk,
    input wire logic              rstn,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              halting_permitted,
    input wire logic [PRIO_W-1:0] exec_priority,
    input wire logic [PRIO_W-1:0] monitor_priority,
    input wire logic              evt_breakpoint_instruction,
    input wire logic              evt_watch,
    input wire logic              evt_other,
    input wire logic              evt_halting,
    input wire logic              instr_retired,
    input wire logic              monitor_taken,
    input wire logic              monitor_pend_req,
    input wire logic              hard_fault_req,
    input wire logic              core_halt,
    input wire logic              step_active,
    input wire logic              irq_block
);
    timeunit 1ns;
    timeprecision 1ns;
    logic monitor_enable_q; // Shadow of monitor enable, from bus writes
    wire logic hi_prio = monitor_priority < exec_priority; // Lower = urgent
    wire logic hctl_wr = reg_wr && reg_addr == OFF_HALT_CTRL;
    wire logic any_evt = evt_breakpoint_instruction || evt_watch || evt_other;
    // Shadow copy, since the enable bit is not a port of its own
    always_ff @(posedge core_clk)
    begin
        if (!rstn)
            monitor_enable_q <= 1'b0;
        else if (reg_wr && reg_addr == OFF_MON_CTRL)
            monitor_enable_q <= reg_wdata[MONITOR_ENABLE_BIT];
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    property p_pend;
        evt_other && !evt_halting && monitor_enable_q && hi_prio |=> monitor_pend_req;
    endproperty
    a_pend: assert property (p_pend) else $error("event not pended");
    property p_esc;
        evt_breakpoint_instruction && !evt_halting && monitor_enable_q && !hi_prio |-> hard_fault_req;
    endproperty
    a_esc: assert property (p_esc) else $error("no escalation");
    property p_ignore;
        evt_other && !evt_breakpoint_instruction && !evt_watch && monitor_enable_q && !hi_prio
        && !monitor_pend_req && !reg_wr |-> !hard_fault_req ##1 !monitor_pend_req;
    endproperty
    a_ignore: assert property (p_ignore) else $error("not ignored");
    property p_take;
        monitor_taken && !any_evt && !reg_wr |=> !monitor_pend_req;
    endproperty
    a_take: assert property (p_take) else $error("pending kept");
    property p_halt;
        halting_permitted [*4] ##0 hctl_wr && reg_wdata[1:0] == 2'b11
        |-> ##[1:3] core_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt");
    property p_step;
        step_active && instr_retired && halting_permitted |-> ##[1:3] core_halt;
    endproperty
    a_step: assert property (p_step) else $error("step not halted");
    property p_nomask;
        !halting_permitted [*4] |-> !irq_block;
    endproperty
    a_nomask: assert property (p_nomask) else $error("mask kept");
    property p_off;
        hctl_wr && !reg_wdata[HDE_BIT] |=> !core_halt && !step_active
        && !irq_block;
    endproperty
    a_off: assert property (p_off) else $error("bits not ignored");
endmodule : dmh_debug_ctrl_asserts
bind dmh_debug_ctrl dmh_debug_ctrl_asserts #(.PRIO_W(PRIO_W)) chk_inst (
    .core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .halting_permitted,
    .exec_priority, .monitor_priority, .evt_breakpoint_instruction, .evt_watch, .evt_other,
    .evt_halting, .instr_retired, .monitor_taken, .monitor_pend_req,
    .hard_fault_req, .core_halt, .step_active, .irq_block
);
`default_nettype wire

// File: sim/tb_top.sv
/*
 * Bench for the debug monitor and halt/step block.
 * Core side driven here, register traffic through the debugger model.
 */
`default_nettype none
module tb_top
    import dmh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk, rstn, reg_wr, reg_rd; // Clock, reset, strobes
    logic [7:0]  reg_addr, exec_priority, monitor_priority;
    logic [31:0] reg_wdata, reg_rdata, rv; // Bus words, last read
    logic        halting_permitted, secure_debug_enabled, security_ext;
    logic        evt_breakpoint_instruction, evt_watch, evt_other, evt_halting; // Events
    logic        instr_retired, exc_entry, monitor_taken, wait_sleeping;
    logic        wake_event, exc_secure, monitor_pend_req, hard_fault_req;
    logic        core_halt, step_active, irq_block, allow_exc_entry;
    int          err_total, checks_done; // Mismatches, compares
    logic [7:0]  adr [4] = '{8'h00, 8'h04, 8'h08, 8'hFC}; // Last unmapped
    dmh_dbg dmh_dbg_inst (.core_clk, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata);
    dmh_debug_ctrl #(.PRIO_W(8)) dmh_debug_ctrl_inst (.core_clk, .rstn,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .halting_permitted, .secure_debug_enabled, .security_ext,
        .exec_priority, .monitor_priority, .evt_breakpoint_instruction, .evt_watch, .evt_other,
        .evt_halting, .instr_retired, .exc_entry, .monitor_taken,
        .wait_sleeping, .wake_event, .exc_secure, .monitor_pend_req,
        .hard_fault_req, .core_halt, .step_active, .irq_block,
        .allow_exc_entry);
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : chk
    // Verdict and end of run
    task automatic summarize;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    // Bounded wait for the core to stop
    task automatic wait_halt;
        #1;
        for (int n = 0; core_halt !== 1'b1; n++)
        begin
            if (n == 20)
            begin
                err_total++;
                summarize();
            end
            @(posedge core_clk);
            #1;
        end
    endtask : wait_halt
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // Main sequence; secure debug off so the mask can be tried on it
    initial
    begin
        err_total = 0;
        checks_done = 0;
        {rstn, secure_debug_enabled, exc_secure, exc_entry} = 4'h0;
        {evt_breakpoint_instruction, evt_watch, evt_other, evt_halting} = 4'h0;
        {instr_retired, monitor_taken, wait_sleeping, wake_event} = 4'h0;
        {halting_permitted, security_ext} = 2'b11;
        exec_priority = 8'h05;
        monitor_priority = 8'h02;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        #1;
        chk({31'h0, allow_exc_entry}, 32'h1);
        foreach (adr[i])
        begin
            dmh_dbg_inst.rd(adr[i], rv);
            chk(rv, 32'h0);
        end
        dmh_dbg_inst.wr(OFF_MON_CTRL, 32'h1);
        @(posedge core_clk) evt_other <= 1'b1;
        @(posedge core_clk) evt_other <= 1'b0;
        #1;
        chk({31'h0, monitor_pend_req}, 32'h1);
        dmh_dbg_inst.rd(OFF_MON_CTRL, rv);
        chk(rv, 32'h3);
        dmh_dbg_inst.rd(OFF_FAULT_ST, rv);
        chk(rv, 32'h8);
        @(posedge core_clk) monitor_taken <= 1'b1;
        @(posedge core_clk) monitor_taken <= 1'b0;
        #1;
        chk({31'h0, monitor_pend_req}, 32'h0);
        exec_priority <= 8'h01;
        @(posedge core_clk) evt_breakpoint_instruction <= 1'b1;
        #1;
        chk({31'h0, hard_fault_req}, 32'h1);
        @(posedge core_clk) evt_breakpoint_instruction <= 1'b0;
        evt_other <= 1'b1;
        #1;
        chk({31'h0, hard_fault_req}, 32'h0);
        @(posedge core_clk) evt_other <= 1'b0;
        dmh_dbg_inst.rd(OFF_MON_CTRL, rv);
        chk(rv, 32'h1);
        dmh_dbg_inst.wr(OFF_HALT_CTRL, 32'h3);
        wait_halt();
        dmh_dbg_inst.rd(OFF_HALT_CTRL, rv);
        chk(rv & 32'h1_0003, 32'h1_0003);
        dmh_dbg_inst.wr(OFF_HALT_CTRL, 32'h5);
        @(posedge core_clk); // Sequencer leaves halt one edge later
        #1;
        chk({30'h0, step_active, core_halt}, 32'h2);
        @(posedge core_clk) instr_retired <= 1'b1;
        @(posedge core_clk) instr_retired <= 1'b0;
        wait_halt();
        dmh_dbg_inst.rd(OFF_FAULT_ST, rv);
        chk(rv & 32'h1, 32'h1);
        dmh_dbg_inst.rd(OFF_HALT_CTRL, rv);
        chk(rv & 32'h2, 32'h2);
        dmh_dbg_inst.wr(OFF_HALT_CTRL, 32'h9);
        @(posedge core_clk); // Exit to run takes one more edge
        #1;
        chk({30'h0, irq_block, core_halt}, 32'h2);
        exc_secure <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        chk({31'h0, irq_block}, 32'h0);
        exc_secure <= 1'b0;
        halting_permitted <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk({31'h0, irq_block}, 32'h0);
        dmh_dbg_inst.wr(OFF_HALT_CTRL, 32'hB);
        repeat (4) @(posedge core_clk);
        #1;
        chk({31'h0, core_halt}, 32'h0);
        halting_permitted <= 1'b1;
        wait_halt();
        dmh_dbg_inst.wr(OFF_HALT_CTRL, 32'h2);
        #1;
        chk({31'h0, core_halt}, 32'h0);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
